// ===== rtl/sdpd_clip_lane.sv
`timescale 1ns/10ps
// Signed clip of one element to [-2^k, 2^k-1]
module sdpd_clip_lane #(
	parameter int W  = 8,
	parameter int KW = 3
) (
	input  wire logic [W-1:0]  i_val,   // Element in
	input  wire logic [KW-1:0] i_k,     // Range exponent
	output logic      [W-1:0]  o_val,   // Clipped element
	output logic               o_sat    // Element was changed
);
	logic [W:0] hi;                     // 2^k - 1, one bit wider
	logic [W:0] lo;                     // -2^k, one bit wider
	logic [W:0] v;                      // Sign-extended input

	// Bounds and compare
	always_comb begin
		hi = ({{W{1'b0}}, 1'b1} << i_k) - {{W{1'b0}}, 1'b1};
		lo = ~hi;
		v  = {i_val[W-1], i_val};
		o_val = i_val;
		o_sat = 1'b0;
		if ($signed(v) > $signed(hi)) begin
			o_val = hi[W-1:0];
			o_sat = 1'b1;
		end else if ($signed(v) < $signed(lo)) begin
			o_val = lo[W-1:0];
			o_sat = 1'b1;
		end
	end
endmodule : sdpd_clip_lane

// ===== rtl/sdpd_datapath.sv
`timescale 1ns/10ps
`include "sdpd_map.svh"
// Behaviour
// - decode straight add-sub halfword, upper add, lower sub
// - saturate halfwords to Q15, set flag
// - decode byte clip, 3-bit range immediate
// - clip sets flag only when changing element
// - decode halfword clip, 4-bit range immediate
// - decode word clip, 5-bit range immediate
// - halving word subtract, arithmetic shift one
// - halving subtract keeps extra bit, no flag
// - pack source one high, source two low
// - signed byte pair unpack to halfwords
// - unsigned byte pair unpack to halfwords
// - no exceptions, any privilege level
module sdpd_datapath (
	input  wire logic        i_clk,         // Core clock
	input  wire logic        i_rst_n,       // Async reset, active low
	input  wire logic        i_valid,       // Instruction issued this cycle
	input  wire logic [31:0] i_instr,       // Instruction word
	input  wire logic [63:0] i_rs1,         // Source one pair
	input  wire logic [63:0] i_rs2,         // Source two pair
	output logic             o_hit,         // Instruction belongs to this block
	output logic             o_rd_valid,    // Result ready, one cycle
	output logic [63:0]      o_rd,          // Result pair
	output logic             o_overflow_flag // Sticky overflow
);
	sdpd_pkg::sdpd_op_t op;                 // Decoded operation
	logic [6:0]  f7;                        // Function seven field
	logic [4:0]  sel;                       // Rs2 / immediate field
	logic [63:0] res;                       // Combinational result
	logic        ovf_set;                   // Saturation event this op
	logic [63:0] c8_v, c16_v, c32_v;        // Clip lane outputs
	logic [7:0]  c8_s;                      // Byte lane saturations
	logic [3:0]  c16_s;                     // Halfword lane saturations
	logic [1:0]  c32_s;                     // Word lane saturations
	logic [63:0] stas_v;                    // Add-sub results
	logic [3:0]  stas_s;                    // Add-sub saturations
	logic [63:0] hsub_v;                    // Halving subtract results
	logic [63:0] unpk_v;                    // Unpack results
	logic [63:0] rd_q;                      // Result register
	logic        rd_valid_q;                // Result strobe
	logic        ovf_q;                     // Sticky flag

	assign f7  = i_instr[`SDPD_F7_MSB:`SDPD_F7_LSB];
	assign sel = i_instr[`SDPD_IMM_LSB+4:`SDPD_IMM_LSB];

	// Instruction decode
	always_comb begin
		op = sdpd_pkg::SDPD_OP_NONE;
		if (i_valid && i_instr[`SDPD_OPC_MSB:0] == `SDPD_OPC_CUSTOM3
			&& i_instr[`SDPD_F3_MSB:`SDPD_F3_LSB] == `SDPD_F3_ZERO) begin
			unique case (f7)
				`SDPD_F7_STAS16: op = sdpd_pkg::SDPD_OP_STAS16;
				// byte clip needs bits 24-23 zero
				`SDPD_F7_CLIP8: if (sel[4:3] == 2'h0) op = sdpd_pkg::SDPD_OP_CLIP8;
				// halfword clip needs bit 24 zero
				`SDPD_F7_CLIP16: if (!sel[4]) op = sdpd_pkg::SDPD_OP_CLIP16;
				`SDPD_F7_CLIP32: op = sdpd_pkg::SDPD_OP_CLIP32;
				`SDPD_F7_HSUB32: op = sdpd_pkg::SDPD_OP_HSUB32;
				`SDPD_F7_PACK32: op = sdpd_pkg::SDPD_OP_PACK32;
				`SDPD_F7_UNPK: begin
					if (sel >= `SDPD_SEL_S10 && sel <= `SDPD_SEL_S32)
						op = sdpd_pkg::SDPD_OP_SUNPK;
					else if (sel >= `SDPD_SEL_U10 && sel <= `SDPD_SEL_U32)
						op = sdpd_pkg::SDPD_OP_ZUNPK;
				end
				default: op = sdpd_pkg::SDPD_OP_NONE;
			endcase
		end
	end

	// Clip lanes, one instance per element
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_c8
			sdpd_clip_lane #(.W(8), .KW(3)) u_c8 (
				.i_val (i_rs1[8*g +: 8]),
				.i_k   (sel[2:0]),
				.o_val (c8_v[8*g +: 8]),
				.o_sat (c8_s[g])
			);
		end
		for (g = 0; g < 4; g++) begin : g_c16
			sdpd_clip_lane #(.W(16), .KW(4)) u_c16 (
				.i_val (i_rs1[16*g +: 16]),
				.i_k   (sel[3:0]),
				.o_val (c16_v[16*g +: 16]),
				.o_sat (c16_s[g])
			);
		end
		for (g = 0; g < 2; g++) begin : g_c32
			sdpd_clip_lane #(.W(32), .KW(5)) u_c32 (
				.i_val (i_rs1[32*g +: 32]),
				.i_k   (sel),
				.o_val (c32_v[32*g +: 32]),
				.o_sat (c32_s[g])
			);
		end
	endgenerate

	// Straight add-sub on halfwords with Q15 saturation
	always_comb begin
		logic [16:0] s;
		s = 17'h00000;
		stas_v = 64'h0;
		stas_s = 4'h0;
		for (int k = 0; k < 4; k++) begin
			if (k[0])
				s = {i_rs1[16*k+15], i_rs1[16*k +: 16]} + {i_rs2[16*k+15], i_rs2[16*k +: 16]};
			else
				s = {i_rs1[16*k+15], i_rs1[16*k +: 16]} - {i_rs2[16*k+15], i_rs2[16*k +: 16]};
			if (s[16] != s[15]) begin
				stas_v[16*k +: 16] = s[16] ? 16'h8000 : 16'h7FFF;
				stas_s[k] = 1'b1;
			end else begin
				stas_v[16*k +: 16] = s[15:0];
			end
		end
	end

	// Halving subtract, 33-bit difference, never saturates
	always_comb begin
		logic [32:0] d;
		d = 33'h000000000;
		hsub_v = 64'h0;
		for (int k = 0; k < 2; k++) begin
			d = {i_rs1[32*k+31], i_rs1[32*k +: 32]} - {i_rs2[32*k+31], i_rs2[32*k +: 32]};
			hsub_v[32*k +: 32] = d[32:1];
		end
	end

	// Byte pair unpack per 32-bit chunk
	always_comb begin
		logic [1:0] bx, by;
		logic [2:0] idx;
		logic       sgn;
		logic [7:0] xb, yb;
		bx = 2'h1;
		by = 2'h0;
		idx = 3'h0;
		sgn = 1'b0;
		xb = 8'h00;
		yb = 8'h00;
		unpk_v = 64'h0;
		sgn = (op == sdpd_pkg::SDPD_OP_SUNPK);
		idx = sgn ? 3'(sel - `SDPD_SEL_S10) : 3'(sel - `SDPD_SEL_U10);
		// Pair order 10, 20, 30, 31, 32
		case (idx)
			3'h0: begin bx = 2'h1; by = 2'h0; end
			3'h1: begin bx = 2'h2; by = 2'h0; end
			3'h2: begin bx = 2'h3; by = 2'h0; end
			3'h3: begin bx = 2'h3; by = 2'h1; end
			default: begin bx = 2'h3; by = 2'h2; end
		endcase
		for (int m = 0; m < 2; m++) begin
			xb = i_rs1[32*m + 8*bx +: 8];
			yb = i_rs1[32*m + 8*by +: 8];
			unpk_v[32*m+16 +: 16] = {{8{sgn & xb[7]}}, xb};
			unpk_v[32*m +: 16]    = {{8{sgn & yb[7]}}, yb};
		end
	end

	// Result and event select
	always_comb begin
		res = 64'h0;
		ovf_set = 1'b0;
		unique case (op)
			sdpd_pkg::SDPD_OP_NONE: res = 64'h0;
			sdpd_pkg::SDPD_OP_STAS16: begin
				res = stas_v;
				ovf_set = |stas_s;
			end
			sdpd_pkg::SDPD_OP_CLIP8: begin
				res = c8_v;
				ovf_set = |c8_s;
			end
			sdpd_pkg::SDPD_OP_CLIP16: begin
				res = c16_v;
				ovf_set = |c16_s;
			end
			sdpd_pkg::SDPD_OP_CLIP32: begin
				res = c32_v;
				ovf_set = |c32_s;
			end
			sdpd_pkg::SDPD_OP_HSUB32: res = hsub_v;
			sdpd_pkg::SDPD_OP_PACK32: res = {i_rs1[31:0], i_rs2[31:0]};
			sdpd_pkg::SDPD_OP_SUNPK,
			sdpd_pkg::SDPD_OP_ZUNPK: res = unpk_v;
		endcase
	end

	assign o_hit = (op != sdpd_pkg::SDPD_OP_NONE);

	// Result register, one cycle latency
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_q       <= 64'h0;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= o_hit;
			if (o_hit) begin
				rd_q <= res;
			end
		end
	end

	// Sticky overflow flag
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ovf_q <= `SDPD_OVF_RST;
		end else if (ovf_set) begin
			ovf_q <= 1'b1;
		end
	end

	assign o_rd            = rd_q;
	assign o_rd_valid      = rd_valid_q;
	assign o_overflow_flag = ovf_q;

	AST_OVF_STICKY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$past(ovf_q) |-> ovf_q) else $error("overflow flag cleared");

	// saturated add-sub raises flag next cycle
	AST_STAS_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_STAS16 && |stas_s) |=> o_overflow_flag)
		else $error("add-sub saturation missed flag");

	// in-range word clip leaves flag and data alone
	AST_CLIP_PASS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_CLIP32 && c32_s == 2'h0 && !ovf_q)
		|=> (!o_overflow_flag && o_rd == $past(i_rs1)))
		else $error("in-range clip changed data or flag");

	AST_HSUB_NOFLAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_HSUB32 && !ovf_q) |=> !o_overflow_flag)
		else $error("halving subtract set flag");

	AST_PACK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_PACK32)
		|=> (o_rd_valid && o_rd == {$past(i_rs1[31:0]), $past(i_rs2[31:0])}))
		else $error("pack layout wrong");

	// unsigned unpack upper bytes of halfwords zero
	AST_ZUNPK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_ZUNPK)
		|=> (o_rd[63:56] == 8'h00 && o_rd[47:40] == 8'h00
			&& o_rd[31:24] == 8'h00 && o_rd[15:8] == 8'h00))
		else $error("unsigned unpack not zero extended");

	// signed 10 pair sign extends byte 0
	AST_SUNPK10: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_SUNPK && sel == `SDPD_SEL_S10)
		|=> o_rd[15:0] == {{8{$past(i_rs1[7])}}, $past(i_rs1[7:0])})
		else $error("signed unpack low half wrong");

	// every hit yields a result strobe
	AST_ALWAYS_DONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_hit |=> o_rd_valid) else $error("hit without result");

	// add-sub lane 1 sum without saturation
	AST_STAS_SUM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_STAS16 && !stas_s[1])
		|=> o_rd[31:16] == 16'($past(i_rs1[31:16]) + $past(i_rs2[31:16])))
		else $error("add-sub upper sum wrong");

	AST_HSUB_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_HSUB32)
		|=> o_rd[31:0] == 32'(($signed({$past(i_rs1[31]), $past(i_rs1[31:0])})
			- $signed({$past(i_rs2[31]), $past(i_rs2[31:0])})) >>> 1))
		else $error("halving subtract low word wrong");

	AST_CLIP8_WIDE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_CLIP8 && sel[2:0] == 3'h7) |=> o_rd == $past(i_rs1))
		else $error("widest byte clip changed data");

	AST_CLIP16_WIDE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_CLIP16 && sel[3:0] == 4'hF) |=> o_rd == $past(i_rs1))
		else $error("widest halfword clip changed data");

	AST_CLIP32_WIDE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_CLIP32 && sel == 5'h1F) |=> o_rd == $past(i_rs1))
		else $error("widest word clip changed data");

	// narrowest halfword clip of a wide value flags
	AST_CLIP16_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(op == sdpd_pkg::SDPD_OP_CLIP16 && sel[3:0] == 4'h0
			&& i_rs1[15:0] != 16'h0000 && i_rs1[15:0] != 16'hFFFF) |=> o_overflow_flag)
		else $error("narrow halfword clip missed flag");

	AST_OPC_REFUSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_instr[`SDPD_OPC_MSB:0] != `SDPD_OPC_CUSTOM3) |-> !o_hit)
		else $error("foreign opcode decoded");
endmodule : sdpd_datapath

// ===== rtl/sdpd_map.svh
`ifndef SDPD_MAP_SVH
`define SDPD_MAP_SVH
// Opcode and function codes of the instruction word
`define SDPD_OPC_CUSTOM3     7'h7B
`define SDPD_OPC_MSB         6
`define SDPD_F3_ZERO         3'h0
`define SDPD_F7_STAS16       7'h5A
`define SDPD_F7_CLIP8        7'h5B
`define SDPD_F7_CLIP16       7'h5C
`define SDPD_F7_CLIP32       7'h5D
`define SDPD_F7_HSUB32       7'h52
`define SDPD_F7_PACK32       7'h66
`define SDPD_F7_UNPK         7'h06
// Unpack selector codes, signed then unsigned
`define SDPD_SEL_S10         5'h04
`define SDPD_SEL_S32         5'h08
`define SDPD_SEL_U10         5'h09
`define SDPD_SEL_U32         5'h0D
// Instruction field positions
`define SDPD_F7_MSB          31
`define SDPD_F7_LSB          25
`define SDPD_IMM_LSB         20
`define SDPD_F3_MSB          14
`define SDPD_F3_LSB          12
// Reset value of the sticky flag
`define SDPD_OVF_RST         1'b0
`endif

// ===== rtl/sdpd_pkg.sv
package sdpd_pkg;
	// Operation selected by decode, one-hot
	typedef enum logic [8:0] {
		SDPD_OP_NONE   = 9'h001,
		SDPD_OP_STAS16 = 9'h002,
		SDPD_OP_CLIP8  = 9'h004,
		SDPD_OP_CLIP16 = 9'h008,
		SDPD_OP_CLIP32 = 9'h010,
		SDPD_OP_HSUB32 = 9'h020,
		SDPD_OP_PACK32 = 9'h040,
		SDPD_OP_SUNPK  = 9'h080,
		SDPD_OP_ZUNPK  = 9'h100
	} sdpd_op_t;
endpackage : sdpd_pkg

// ===== testbench/sdpd_core_model.sv
`timescale 1ns/10ps
// Issue side of the core: presents one instruction for one cycle
module sdpd_core_model (
	input  wire logic        i_clk,   // Core clock
	output logic             o_valid, // Instruction issued
	output logic [31:0]      o_instr, // Instruction word
	output logic [63:0]      o_rs1,   // Source one pair
	output logic [63:0]      o_rs2    // Source two pair
);
	// Idle values at time zero
	initial begin
		o_valid = 1'b0;
		o_instr = 32'h0;
		o_rs1   = 64'h0;
		o_rs2   = 64'h0;
	end

	// Drive a request just after the falling edge
	task automatic issue(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
		@(negedge i_clk);
		o_valid = 1'b1;
		o_instr = w;
		o_rs1   = a;
		o_rs2   = b;
	endtask : issue

	// Release after one cycle; stale operands are inverted so nothing leans on them
	task automatic retire();
		@(negedge i_clk);
		o_valid = 1'b0;
		o_instr = ~o_instr;
		o_rs1   = ~o_rs1;
		o_rs2   = ~o_rs2;
	endtask : retire
endmodule : sdpd_core_model

// ===== testbench/simd_dsp_pair_datapath_tb.sv
`timescale 1ns/10ps
`include "sdpd_map.svh"
module simd_dsp_pair_datapath_tb;
	logic        clk = 1'b0; // Core clock
	logic        rst_n;      // Reset, active low
	logic        valid;      // Issue strobe
	logic        hit;        // Decode hit
	logic        rd_valid;   // Result strobe
	logic        ovf;        // Sticky flag
	logic        exp_ovf;    // Expected flag
	logic [31:0] instr;      // Instruction word
	logic [63:0] rs1;        // Source one
	logic [63:0] rs2;        // Source two
	logic [63:0] rd;         // Result
	int          n_mismatch = 0;
	int          cmp_count  = 0;
	localparam logic [63:0] PAT = 64'h7F80_0103_FFFE_8001; // Mixed-sign operand

	// 40 MHz clock
	always #12.5 clk = ~clk;

	sdpd_core_model u_sdpd_core_model (.i_clk(clk), .o_valid(valid), .o_instr(instr),
		.o_rs1(rs1), .o_rs2(rs2));
	sdpd_datapath u_sdpd_datapath (.i_clk(clk), .i_rst_n(rst_n), .i_valid(valid),
		.i_instr(instr), .i_rs1(rs1), .i_rs2(rs2), .o_hit(hit), .o_rd_valid(rd_valid),
		.o_rd(rd), .o_overflow_flag(ovf));

	// Compare and count
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task automatic close_out();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	// Instruction word with custom opcode
	function automatic logic [31:0] enc(input logic [6:0] f7, input logic [4:0] f, input logic [2:0] f3);
		enc = {f7, f, 5'h01, f3, 5'h02, `SDPD_OPC_CUSTOM3};
	endfunction : enc

	// Signed clip of every w-bit element to the k range
	function automatic logic [63:0] clip(input logic [63:0] v, input int w, input int k, output logic s);
		longint e;
		longint hi;
		clip = 64'h0;
		s = 1'b0;
		hi = (longint'(1) << k) - 1;
		for (int i = 0; i < 64 / w; i++) begin
			e = $signed(v << (64 - w - i * w)) >>> (64 - w);
			if (e > hi) begin
				e = hi;
				s = 1'b1;
			end else if (e < -hi - 1) begin
				e = -hi - 1;
				s = 1'b1;
			end
			clip = clip | ((64'(e) & ((64'h1 << w) - 1)) << (i * w));
		end
	endfunction : clip

	// Byte pair to halfwords in each chunk
	function automatic logic [63:0] upk(input logic [63:0] a, input int x, input int y, input logic sg);
		logic [7:0] bx;
		logic [7:0] by;
		for (int m = 0; m < 2; m++) begin
			bx = a[m * 32 + x * 8 +: 8];
			by = a[m * 32 + y * 8 +: 8];
			upk[m * 32 + 16 +: 16] = sg ? {{8{bx[7]}}, bx} : {8'h00, bx};
			upk[m * 32 +: 16] = sg ? {{8{by[7]}}, by} : {8'h00, by};
		end
	endfunction : upk

	// Reset for ten cycles, then look at the cleared outputs
	task automatic do_reset();
		rst_n = 1'b0;
		exp_ovf = 1'b0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		check(rd, 64'h0);
		check({62'h0, rd_valid, ovf}, 64'h0);
	endtask : do_reset

	// Issue one op, judge hit, strobe, result and flag
	task automatic run(input logic [31:0] w, input logic [63:0] a, b, e, input logic h, s);
		logic [63:0] held;
		held = rd;
		u_sdpd_core_model.issue(w, a, b);
		#1;
		check({63'h0, hit}, {63'h0, h});
		u_sdpd_core_model.retire();
		exp_ovf = exp_ovf | s;
		check({63'h0, rd_valid}, {63'h0, h});
		check({63'h0, ovf}, {63'h0, exp_ovf});
		if (h) begin
			check(rd, e);
		end else begin
			check(rd, held);
		end
		@(negedge clk);
		check({63'h0, rd_valid}, 64'h0);
	endtask : run

	// Halving subtract at the extremes, then pack
	task automatic t_halve_pack();
		run(enc(`SDPD_F7_HSUB32, 5'h03, 3'h0), 64'h8000_0000_7FFF_FFFF,
			64'h7FFF_FFFF_8000_0000, 64'h8000_0000_7FFF_FFFF, 1'b1, 1'b0);
		run(enc(`SDPD_F7_HSUB32, 5'h03, 3'h0), 64'h0000_0005_FFFF_FFF9,
			64'h0000_0002_0000_0000, 64'h0000_0001_FFFF_FFFC, 1'b1, 1'b0);
		run(enc(`SDPD_F7_PACK32, 5'h03, 3'h0), 64'h1111_1111_2222_2222,
			64'h3333_3333_4444_4444, 64'h2222_2222_4444_4444, 1'b1, 1'b0);
	endtask : t_halve_pack

	// Every unpack selector, signed then unsigned
	task automatic t_unpack();
		int xs[5] = '{1, 2, 3, 3, 3};
		int ys[5] = '{0, 0, 0, 1, 2};
		for (int i = 0; i < 10; i++) begin
			run(enc(`SDPD_F7_UNPK, 5'(4 + i), 3'h0), 64'h80FF_7F01_8283_8485, 64'h0,
				upk(64'h80FF_7F01_8283_8485, xs[i % 5], ys[i % 5], i < 5), 1'b1, 1'b0);
		end
	endtask : t_unpack

	// Encodings outside the set are refused
	task automatic t_refused();
		run(enc(`SDPD_F7_CLIP8, 5'h18, 3'h0), PAT, PAT, 64'h0, 1'b0, 1'b0);
		run(enc(`SDPD_F7_CLIP16, 5'h10, 3'h0), PAT, PAT, 64'h0, 1'b0, 1'b0);
		run(enc(`SDPD_F7_UNPK, 5'h0E, 3'h0), PAT, PAT, 64'h0, 1'b0, 1'b0);
		run(enc(`SDPD_F7_UNPK, 5'h03, 3'h0), PAT, PAT, 64'h0, 1'b0, 1'b0);
		run(enc(`SDPD_F7_PACK32, 5'h03, 3'h1), PAT, PAT, 64'h0, 1'b0, 1'b0);
		run(enc(`SDPD_F7_PACK32, 5'h03, 3'h0) ^ 32'h1, PAT, PAT, 64'h0, 1'b0, 1'b0);
	endtask : t_refused

	// Plain and saturating add-sub, then flag must stay set
	task automatic t_stas();
		run(enc(`SDPD_F7_STAS16, 5'h03, 3'h0), 64'h1000_2000_FFFF_0000,
			64'h0100_0200_0001_0001, 64'h1100_1E00_0000_FFFF, 1'b1, 1'b0);
		run(enc(`SDPD_F7_STAS16, 5'h03, 3'h0), 64'h7FFF_8000_0001_0005,
			64'h0001_0001_0002_0003, 64'h7FFF_8000_0003_0002, 1'b1, 1'b1);
		run(enc(`SDPD_F7_PACK32, 5'h03, 3'h0), 64'h0, 64'h1, 64'h1, 1'b1, 1'b0);
	endtask : t_stas

	// Clip sweep from widest range down, flag only once an element changes
	task automatic t_clip(input logic [6:0] f7, input int w, input int kmax);
		logic [63:0] e;
		logic        s;
		do_reset();
		for (int k = kmax; k >= 0; k--) begin
			e = clip(PAT, w, k, s);
			run(enc(f7, 5'(k), 3'h0), PAT, ~PAT, e, 1'b1, s);
		end
	endtask : t_clip

	// Main sequence
	initial begin
		rst_n = 1'b0;
		exp_ovf = 1'b0;
		do_reset();
		t_halve_pack();
		t_unpack();
		t_refused();
		t_stas();
		t_clip(`SDPD_F7_CLIP8, 8, 7);
		t_clip(`SDPD_F7_CLIP16, 16, 15);
		t_clip(`SDPD_F7_CLIP32, 32, 31);
		close_out();
	end
endmodule : simd_dsp_pair_datapath_tb
